//--- src/slw_pkg.sv
// Shared constants, types and pulse helpers for the pulse link codec
package slw_pkg;
    // Clock and pulse timing in nanoseconds
    localparam int CLK_NS = 100;
    localparam int LONG_HALF_NS = 150;
    localparam int SHORT_HALF_NS = 50;
    localparam int DWELL_NS = 240;

    // Least times round up to whole cycles
    localparam int LONG_HALF = (LONG_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SHORT_HALF = (SHORT_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DWELL_CYC = (DWELL_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LAT = 2;

    // Counter-width forms of the pulse figures
    localparam logic [2:0] LONG_HALF_W = 3'(LONG_HALF);
    localparam logic [2:0] SHORT_HALF_W = 3'(SHORT_HALF);
    localparam logic [2:0] LONG_LEN = 3'(2 * LONG_HALF);
    localparam logic [2:0] SHORT_LEN = 3'(2 * SHORT_HALF);
    // Half-width at or above this is a long pulse
    localparam logic [2:0] LONG_THR = 3'((LONG_HALF + SHORT_HALF + 1) / 2);
    localparam logic [2:0] DWELL_LAST = 3'(DWELL_CYC - 1);

    // Bit positions in the device's synchroniser vector
    localparam int P_MODE = 7;
    localparam int P_CSB = 6;
    localparam int P_SCK = 5;
    localparam int P_SDI = 4;
    localparam int P_LP = 3;
    localparam int P_LN = 2;
    localparam int P_UP = 1;
    localparam int P_UN = 0;

    // Reset values of the reconstructed SPI lines
    localparam logic RST_CSB = 1'b1;
    localparam logic RST_SDO = 1'b1;
    localparam int DUMMY_BITS = 8;

    // Link events, each mapped onto one of four pulse types
    typedef enum logic [1:0] {
        SLW_EV_CS_RISE = 2'h0,
        SLW_EV_CS_FALL = 2'h1,
        SLW_EV_BIT0 = 2'h2,
        SLW_EV_BIT1 = 2'h3
    } slw_ev_t;

    typedef enum logic [2:0] {
        SLW_PS_IDLE = 3'b001,
        SLW_PS_WAKING = 3'b010,
        SLW_PS_READY = 3'b100
    } slw_pst_t;

    typedef enum logic [3:0] {
        SLW_HS_IDLE = 4'b0001,
        SLW_HS_TX = 4'b0010,
        SLW_HS_LISTEN = 4'b0100,
        SLW_HS_GAP = 4'b1000
    } slw_hst_t;

    function automatic logic slw_ev_long(slw_ev_t ev);
        return ev == SLW_EV_CS_RISE || ev == SLW_EV_CS_FALL;
    endfunction

    function automatic logic slw_ev_plus(slw_ev_t ev);
        return ev == SLW_EV_CS_RISE || ev == SLW_EV_BIT1;
    endfunction

    // Levels {pos, neg} of a pulse from its remaining cycle count
    function automatic logic [1:0] slw_tx_drive(logic [2:0] cnt, logic lng,
                                                logic plus);
        logic first;
        first = cnt > (lng ? LONG_HALF_W : SHORT_HALF_W);
        if (cnt == 3'h0) begin
            return 2'h0;
        end
        return {plus == first, plus != first};
    endfunction
endpackage

//--- src/slw_link_if.sv
// Two-wire pulse link between the host end and the device's lower port
`timescale 1ns/10ps
`default_nettype none
interface slw_link_if;
    logic host_pos;
    logic host_neg;
    logic host_pos_oe;
    logic host_neg_oe;
    logic dev_pos;
    logic dev_neg;
    logic dev_pos_oe;
    logic dev_neg_oe;
    logic lower_pos_line;
    logic lower_neg_line;

    // A wire is high while any enabled driver pulls it high
    assign lower_pos_line = (host_pos_oe & host_pos) | (dev_pos_oe & dev_pos);
    assign lower_neg_line = (host_neg_oe & host_neg) | (dev_neg_oe & dev_neg);

    modport host (
        output host_pos, host_neg, host_pos_oe, host_neg_oe,
        input lower_pos_line, lower_neg_line
    );
    modport dev (
        output dev_pos, dev_neg, dev_pos_oe, dev_neg_oe,
        input lower_pos_line, lower_neg_line
    );
endinterface
`default_nettype wire

//--- src/slw_dev_end.sv
// Device end: SPI or pulse lower port, pulse upper port, idle and wake
//
// How it works
// - Mode pin picks SPI or pulse lower port
// - SPI mode sees four chip-select and clock events
// - Upper port encodes events as long/short pulses
// - Pulse is two opposite halves, then zero
// - Received pulses rebuild chip-select, data and clock
// - Read answers each bit 0 with short minus
// - Lower port only ever sends short minus
// - Missing return means 1, short minus means 0
// - Read data valid by next clock rise
// - Own data first, then higher devices' data
// - No lower activity for timeout means idle
// - Chip-select, clock or pair activity wakes
// - Wake needs difference held for dwell time
// - Ready after wake or ready time by core
// - Woken device sends one long plus upward
// - Ready device sends no wake pulse
// - Host may send dummy byte for long chains
// - Host sends spaced long pulse pair per device
// - Host makes pairs by toggling chip-select
`timescale 1ns/10ps
`default_nettype none
module slw_dev_end #(
    parameter int IDLE_CYCLES = 20000,
    parameter int WAKE_CYCLES = 2000,
    parameter int READY_CYCLES = 100,
    parameter int UP_WIN = 4
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    slw_link_if.dev lower,
    input wire logic port_mode_select_in,
    input wire logic spi_csb_in,
    input wire logic spi_sck_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    input wire logic upper_pos_in,
    input wire logic upper_neg_in,
    output logic upper_pos_out,
    output logic upper_neg_out,
    output logic upper_pos_oe_out,
    output logic upper_neg_oe_out,
    input wire logic core_standby_in,
    input wire logic core_read_in,
    input wire logic core_own_in,
    input wire logic core_bit_in,
    output logic core_csb_out,
    output logic core_sck_out,
    output logic core_sdi_out,
    output logic iface_ready_out
);
    localparam logic [23:0] IDLE_LAST = 24'(IDLE_CYCLES - 1);
    localparam logic [23:0] WAKE_LAST = 24'(WAKE_CYCLES - 1);
    localparam logic [23:0] READY_LAST = 24'(READY_CYCLES - 1);
    // Window covers our own pulse, its echo, then the answer slot
    localparam logic [3:0] UW_LEN =
        4'(UP_WIN + 2 * slw_pkg::SHORT_HALF + slw_pkg::SYNC_LAT);
    localparam logic [3:0] UW_OPEN = 4'(UP_WIN);

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic csb_p;
        logic sck_p;
        slw_pkg::slw_pst_t pst;
        logic [23:0] tmr;
        logic [2:0] dwell;
        logic wake_pend;
        logic [1:0] rx_ph;
        logic rx_plus;
        logic [2:0] rx_w;
        logic [2:0] ltx_cnt;
        logic [1:0] lmask;
        logic [2:0] utx_cnt;
        logic utx_lng;
        logic utx_plus;
        logic [3:0] uw_cnt;
        logic uzero;
        logic csb;
        logic sck;
        logic sdi;
        logic sdo;
    } slw_dev_state_t;

    localparam slw_dev_state_t DEV_RST = '{
        default: '0,
        pst: slw_pkg::SLW_PS_IDLE,
        csb: slw_pkg::RST_CSB,
        sdo: slw_pkg::RST_SDO
    };

    slw_dev_state_t q;
    slw_dev_state_t n;
    logic [7:0] pins;
    logic [1:0] ldrv;
    logic [1:0] udrv;

    assign pins = {port_mode_select_in, spi_csb_in, spi_sck_in, spi_sdi_in,
                   lower.lower_pos_line, lower.lower_neg_line,
                   upper_pos_in, upper_neg_in};

    // Pulse shapes: the lower port is hard-wired to short minus
    assign ldrv = slw_pkg::slw_tx_drive(q.ltx_cnt, 1'b0, 1'b0);
    assign udrv = slw_pkg::slw_tx_drive(q.utx_cnt, q.utx_lng, q.utx_plus);

    always_comb begin
        slw_pkg::slw_ev_t ev;
        logic ev_ok;
        logic mode;
        logic csb;
        logic sck;
        logic lp;
        logic ln;
        logic up;
        logic un;
        logic diff;
        logic act;
        logic rdo;
        logic rbit;
        logic [23:0] wlast;
        ev = slw_pkg::SLW_EV_CS_RISE;
        ev_ok = 1'b0;
        rdo = 1'b0;
        rbit = 1'b1;
        mode = q.s2[slw_pkg::P_MODE];
        csb = q.s2[slw_pkg::P_CSB];
        sck = q.s2[slw_pkg::P_SCK];
        lp = q.s2[slw_pkg::P_LP];
        ln = q.s2[slw_pkg::P_LN];
        up = q.s2[slw_pkg::P_UP];
        un = q.s2[slw_pkg::P_UN];
        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.csb_p = csb;
        n.sck_p = sck;
        n.sck = 1'b0;
        if (q.ltx_cnt != 3'h0) begin
            n.ltx_cnt = q.ltx_cnt - 3'h1;
        end
        if (q.utx_cnt != 3'h0) begin
            n.utx_cnt = q.utx_cnt - 3'h1;
        end
        // Our own return echoes back through the synchroniser
        n.lmask = {q.lmask[0], q.ltx_cnt != 3'h0};

        // Lower port events, by strap
        if (!mode) begin
            if (q.csb_p && !csb) begin
                ev_ok = 1'b1;
                ev = slw_pkg::SLW_EV_CS_FALL;
            end else if (!q.csb_p && csb) begin
                ev_ok = 1'b1;
                ev = slw_pkg::SLW_EV_CS_RISE;
            end else if (!q.sck_p && sck && !csb) begin
                ev_ok = 1'b1;
                ev = q.s2[slw_pkg::P_SDI] ? slw_pkg::SLW_EV_BIT1
                                          : slw_pkg::SLW_EV_BIT0;
            end
        end else if (q.ltx_cnt == 3'h0 && q.lmask == 2'h0) begin
            // Pulse receiver: first half, second half, back to zero
            unique case (q.rx_ph)
                2'h0: begin
                    if (lp ^ ln) begin
                        n.rx_ph = 2'h1;
                        n.rx_plus = lp;
                        n.rx_w = 3'h1;
                    end
                end
                2'h1: begin
                    if (!(lp ^ ln)) begin
                        n.rx_ph = 2'h0;
                    end else if (lp == q.rx_plus) begin
                        if (q.rx_w != 3'h7) begin
                            n.rx_w = q.rx_w + 3'h1;
                        end
                    end else begin
                        n.rx_ph = 2'h2;
                    end
                end
                2'h2: begin
                    if (!(lp ^ ln)) begin
                        n.rx_ph = 2'h0;
                        ev_ok = 1'b1;
                        if (q.rx_w >= slw_pkg::LONG_THR) begin
                            ev = q.rx_plus ? slw_pkg::SLW_EV_CS_RISE
                                           : slw_pkg::SLW_EV_CS_FALL;
                        end else begin
                            ev = q.rx_plus ? slw_pkg::SLW_EV_BIT1
                                           : slw_pkg::SLW_EV_BIT0;
                        end
                    end else if (lp == q.rx_plus) begin
                        n.rx_ph = 2'h0; // Third level: malformed, drop
                    end
                end
                default: n.rx_ph = 2'h0;
            endcase
        end

        // Common mode (both wires high) never counts as a difference
        diff = mode ? (lp ^ ln) : (sck ^ csb);
        act = mode ? diff : (csb != q.csb_p || sck != q.sck_p);
        n.dwell = diff ? ((q.dwell == 3'h7) ? q.dwell : q.dwell + 3'h1)
                       : 3'h0;
        wlast = core_standby_in ? READY_LAST : WAKE_LAST;

        // Idle, waking and ready
        unique case (q.pst)
            slw_pkg::SLW_PS_IDLE: begin
                n.tmr = 24'h0;
                if (diff && q.dwell >= slw_pkg::DWELL_LAST) begin
                    n.pst = slw_pkg::SLW_PS_WAKING;
                end
            end
            slw_pkg::SLW_PS_WAKING: begin
                if (q.tmr >= wlast) begin
                    n.pst = slw_pkg::SLW_PS_READY;
                    n.tmr = 24'h0;
                    n.wake_pend = 1'b1;
                end else begin
                    n.tmr = q.tmr + 24'h1;
                end
            end
            slw_pkg::SLW_PS_READY: begin
                // Traffic only restarts the timer; no wake pulse here
                if (act) begin
                    n.tmr = 24'h0;
                end else if (q.tmr >= IDLE_LAST) begin
                    n.pst = slw_pkg::SLW_PS_IDLE;
                    n.tmr = 24'h0;
                end else begin
                    n.tmr = q.tmr + 24'h1;
                end
            end
        endcase

        if (!core_read_in) begin
            n.sdo = slw_pkg::RST_SDO;
        end

        // Traffic before ready is lost; only wake-up counts then
        if (ev_ok && q.pst == slw_pkg::SLW_PS_READY) begin
            unique case (ev)
                slw_pkg::SLW_EV_CS_RISE: n.csb = 1'b1;
                slw_pkg::SLW_EV_CS_FALL: n.csb = 1'b0;
                default: begin
                    n.sdi = ev == slw_pkg::SLW_EV_BIT1;
                    n.sck = 1'b1;
                    if (core_read_in && core_own_in) begin
                        rdo = 1'b1;
                        rbit = core_bit_in;
                    end else if (core_read_in) begin
                        n.uw_cnt = UW_LEN;
                        n.uzero = 1'b0;
                    end
                end
            endcase
            // A busy upper port drops the event; slots are far longer
            if (q.utx_cnt == 3'h0) begin
                n.utx_lng = slw_pkg::slw_ev_long(ev);
                n.utx_plus = slw_pkg::slw_ev_plus(ev);
                n.utx_cnt = slw_pkg::slw_ev_long(ev) ? slw_pkg::LONG_LEN
                                                     : slw_pkg::SHORT_LEN;
            end
        end else if (q.wake_pend && q.utx_cnt == 3'h0) begin
            n.wake_pend = 1'b0;
            n.utx_lng = 1'b1;
            n.utx_plus = 1'b1;
            n.utx_cnt = slw_pkg::LONG_LEN;
        end

        // Return slot from the device above
        if (q.uw_cnt != 4'h0) begin
            n.uw_cnt = q.uw_cnt - 4'h1;
            if (q.uw_cnt <= UW_OPEN && un && !up) begin
                n.uzero = 1'b1;
            end
            if (q.uw_cnt == 4'h1) begin
                rdo = 1'b1;
                rbit = !(q.uzero || (un && !up));
            end
        end

        // Answer downward: SDO in SPI mode, short minus for a 0
        if (rdo) begin
            if (!mode) begin
                n.sdo = rbit;
            end else if (!rbit) begin
                n.ltx_cnt = slw_pkg::SHORT_LEN;
            end
        end
    end

    // All state in one register
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= DEV_RST;
        end else begin
            q <= n;
        end
    end

    // Open-drain SDO only pulls low, and only in SPI mode
    assign spi_sdo_out = 1'b0;
    assign spi_sdo_oe_out = !q.s2[slw_pkg::P_MODE] && !q.sdo;
    assign lower.dev_pos = ldrv[1];
    assign lower.dev_neg = ldrv[0];
    assign lower.dev_pos_oe = q.ltx_cnt != 3'h0;
    assign lower.dev_neg_oe = q.ltx_cnt != 3'h0;
    assign upper_pos_out = udrv[1];
    assign upper_neg_out = udrv[0];
    assign upper_pos_oe_out = q.utx_cnt != 3'h0;
    assign upper_neg_oe_out = q.utx_cnt != 3'h0;
    assign core_csb_out = q.csb;
    assign core_sck_out = q.sck;
    assign core_sdi_out = q.sdi;
    assign iface_ready_out = q.pst == slw_pkg::SLW_PS_READY;
endmodule // slw_dev_end
`default_nettype wire

//--- src/slw_host_end.sv
// Host end: drives events as pulses, reads return bits, wakes the chain
`timescale 1ns/10ps
`default_nettype none
module slw_host_end #(
    parameter int RET_WIN = 16,
    parameter int WAKE_GAP = 2500,
    parameter int WAKE_CYCLES = 2000,
    parameter int READY_CYCLES = 100
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    slw_link_if.host link,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_code_in,
    output logic cmd_ready_out,
    output logic rx_valid_out,
    output logic rx_bit_out,
    input wire logic wake_start_in,
    input wire logic wake_method_in,
    input wire logic [3:0] wake_count_in,
    output logic wake_busy_out
);
    localparam logic [5:0] RET_LEN = 6'(RET_WIN);
    localparam logic [5:0] RET_OPEN = 6'(RET_WIN - slw_pkg::SYNC_LAT);
    localparam logic [15:0] GAP_LAST = 16'(WAKE_GAP - 1);
    localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES - 1);
    localparam logic [15:0] READY_LAST = 16'(READY_CYCLES - 1);
    localparam logic [3:0] DUMMY_N = 4'(slw_pkg::DUMMY_BITS);

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        slw_pkg::slw_hst_t st;
        logic [2:0] tx_cnt;
        logic tx_lng;
        logic tx_plus;
        logic is_bit;
        logic [5:0] win;
        logic zero;
        logic rx_valid;
        logic rx_bit;
        logic wk;
        logic wk_m2;
        logic [3:0] wk_left;
        logic [2:0] wk_ph;
        logic [15:0] tmr;
        logic [3:0] rep;
        logic [3:0] bits;
    } slw_host_state_t;

    localparam slw_host_state_t HOST_RST = '{
        default: '0,
        st: slw_pkg::SLW_HS_IDLE
    };

    slw_host_state_t q;
    slw_host_state_t n;
    logic [1:0] drv;

    assign drv = slw_pkg::slw_tx_drive(q.tx_cnt, q.tx_lng, q.tx_plus);

    always_comb begin
        slw_pkg::slw_ev_t gev;
        logic go;
        logic det;
        logic [15:0] glast;
        go = 1'b0;
        gev = slw_pkg::SLW_EV_CS_FALL;
        det = q.s2 == 2'b01; // Negative level only
        glast = (q.wk_ph == 3'h2) ? (q.wk_m2 ? GAP_LAST : WAKE_LAST)
                                  : READY_LAST;
        n = q;
        n.s1 = {link.lower_pos_line, link.lower_neg_line};
        n.s2 = q.s1;
        n.rx_valid = 1'b0;
        if (q.tx_cnt != 3'h0) begin
            n.tx_cnt = q.tx_cnt - 3'h1;
        end
        unique case (q.st)
            slw_pkg::SLW_HS_IDLE: begin
                if (wake_start_in && wake_count_in != 4'h0) begin
                    n.wk = 1'b1;
                    n.wk_m2 = wake_method_in;
                    n.wk_left = wake_count_in;
                    n.wk_ph = 3'h1;
                    go = 1'b1;
                end else if (cmd_valid_in) begin
                    go = 1'b1;
                    gev = slw_pkg::slw_ev_t'(cmd_code_in);
                end
            end
            slw_pkg::SLW_HS_TX: begin
                // One zero cycle separates back-to-back pulses
                if (q.tx_cnt == 3'h0) begin
                    if (!q.wk) begin
                        n.st = q.is_bit ? slw_pkg::SLW_HS_LISTEN
                                        : slw_pkg::SLW_HS_IDLE;
                        n.win = RET_LEN;
                        n.zero = 1'b0;
                    end else if (q.wk_ph == 3'h1) begin
                        go = 1'b1;
                        gev = slw_pkg::SLW_EV_CS_RISE;
                        n.wk_ph = 3'h2;
                    end else if (q.wk_ph == 3'h2) begin
                        n.st = slw_pkg::SLW_HS_GAP;
                        n.tmr = 16'h0;
                        n.rep = q.wk_m2 ? 4'h1 : q.wk_left;
                    end else if (q.bits == 4'h1) begin
                        n.st = slw_pkg::SLW_HS_GAP;
                        n.tmr = 16'h0;
                        n.rep = q.wk_left;
                        n.wk_ph = 3'h4;
                    end else begin
                        n.bits = q.bits - 4'h1;
                        go = 1'b1;
                        gev = slw_pkg::SLW_EV_BIT1;
                    end
                end
            end
            slw_pkg::SLW_HS_LISTEN: begin
                n.win = q.win - 6'h1;
                if (q.win <= RET_OPEN && det) begin
                    n.zero = 1'b1;
                end
                if (q.win == 6'h1) begin
                    n.rx_valid = 1'b1;
                    n.rx_bit = !(q.zero || (q.win <= RET_OPEN && det));
                    n.st = slw_pkg::SLW_HS_IDLE;
                end
            end
            slw_pkg::SLW_HS_GAP: begin
                if (q.tmr < glast) begin
                    n.tmr = q.tmr + 16'h1;
                end else if (q.rep > 4'h1) begin
                    n.tmr = 16'h0;
                    n.rep = q.rep - 4'h1;
                end else if (q.wk_ph == 3'h4) begin
                    n.wk = 1'b0;
                    n.st = slw_pkg::SLW_HS_IDLE;
                end else if (!q.wk_m2) begin
                    n.bits = DUMMY_N;
                    n.wk_ph = 3'h3;
                    go = 1'b1;
                    gev = slw_pkg::SLW_EV_BIT1;
                end else if (q.wk_left == 4'h1) begin
                    n.wk = 1'b0;
                    n.st = slw_pkg::SLW_HS_IDLE;
                end else begin
                    n.wk_left = q.wk_left - 4'h1;
                    n.wk_ph = 3'h1;
                    go = 1'b1;
                end
            end
        endcase
        // Launch the chosen pulse
        if (go) begin
            n.st = slw_pkg::SLW_HS_TX;
            n.is_bit = !slw_pkg::slw_ev_long(gev);
            n.tx_lng = slw_pkg::slw_ev_long(gev);
            n.tx_plus = slw_pkg::slw_ev_plus(gev);
            n.tx_cnt = slw_pkg::slw_ev_long(gev) ? slw_pkg::LONG_LEN
                                                 : slw_pkg::SHORT_LEN;
        end
    end

    // All state in one register
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= HOST_RST;
        end else begin
            q <= n;
        end
    end

    assign link.host_pos = drv[1];
    assign link.host_neg = drv[0];
    assign link.host_pos_oe = q.tx_cnt != 3'h0;
    assign link.host_neg_oe = q.tx_cnt != 3'h0;
    assign cmd_ready_out = q.st == slw_pkg::SLW_HS_IDLE && !q.wk;
    assign rx_valid_out = q.rx_valid;
    assign rx_bit_out = q.rx_bit;
    assign wake_busy_out = q.wk;
endmodule // slw_host_end
`default_nettype wire

//--- test/slw_link_asserts.sv
// Checker on the pulse link wires between host end and device end
`timescale 1ns/10ps
`default_nettype none
module slw_link_asserts (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic host_pos,
    input wire logic host_neg,
    input wire logic host_pos_oe,
    input wire logic host_neg_oe,
    input wire logic dev_pos,
    input wire logic dev_neg,
    input wire logic dev_pos_oe,
    input wire logic dev_neg_oe,
    input wire logic lower_pos_line,
    input wire logic lower_neg_line
);
    logic hp, hn, dp, dn;
    // Clean half levels only; common mode counts as neither
    assign hp = host_pos_oe & host_pos & ~host_neg;
    assign hn = host_neg_oe & host_neg & ~host_pos;
    assign dp = dev_pos_oe & dev_pos & ~dev_neg;
    assign dn = dev_neg_oe & dev_neg & ~dev_pos;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Pulse shapes: two opposite halves, then back to zero
    sequence s_ps;
        hp ##1 hn ##1 !host_pos_oe;
    endsequence
    sequence s_pl;
        hp[*2] ##1 hn[*2] ##1 !host_pos_oe;
    endsequence
    sequence s_ms;
        hn ##1 hp ##1 !host_pos_oe;
    endsequence
    sequence s_ml;
        hn[*2] ##1 hp[*2] ##1 !host_pos_oe;
    endsequence
    host_plus_shape_a: assert property ($rose(host_pos_oe) && hp |-> s_ps or s_pl)
        else $error("host plus pulse misshaped");
    host_minus_shape_a: assert property ($rose(host_pos_oe) && hn |-> s_ms or s_ml)
        else $error("host minus pulse misshaped");
    host_clean_drive_a: assert property (host_pos_oe |-> hp || hn)
        else $error("host drives no clean level");
    dev_short_minus_a: assert property ($rose(dev_neg_oe) |-> dn ##1 dp ##1 !dev_neg_oe)
        else $error("device sent other than short minus");
    dev_clean_drive_a: assert property (dev_pos_oe || dev_neg_oe |-> dp || dn)
        else $error("device drives no clean level");
    line_no_clash_a: assert property (!(lower_pos_line && lower_neg_line))
        else $error("both link wires high");
    ends_no_overlap_a: assert property (!(host_pos_oe && dev_neg_oe))
        else $error("both ends drive at once");
    reply_slot_a: assert property ($rose(dev_neg_oe) |-> $past(host_pos_oe, 4) && !$past(host_pos_oe, 3))
        else $error("reply out of its slot");
endmodule // slw_link_asserts
`default_nettype wire

//--- test/spi_pulse_link_wake_tb.sv
// Bench joining the host end and the device end over the pulse link
`timescale 1ns/10ps
`default_nettype none
module spi_pulse_link_wake_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_code = 2'h0;
    logic wake_start = 1'b0;
    logic wake_method = 1'b1;
    logic [3:0] wcnt = 4'h1;
    logic mode = 1'b1;
    logic standby = 1'b0, rd = 1'b0, obit = 1'b0;
    logic own = 1'b1;
    logic cmd_ready, rx_valid, rx_bit, wake_busy, csb, sdi, ready, up_oe, sck;
    logic sdo, sdo_oe, up_p, up_n, up_noe;
    logic [7:0] ups = 8'h0;
    int mismatches = 0;
    int checks_done = 0;
    slw_link_if lnk();
    always #50 clk = ~clk;
    // Upper drive cycles: a long pulse adds 4, a short one 2
    always @(posedge clk) begin
        if (up_oe === 1'b1) ups <= ups + 8'h1;
    end
    slw_dev_end #(.IDLE_CYCLES(200), .WAKE_CYCLES(20), .READY_CYCLES(5))
    u_slw_dev_end (.clock_in(clk), .rstn_in(rstn), .lower(lnk),
        .port_mode_select_in(mode), .spi_csb_in(1'b1), .spi_sck_in(1'b1),
        .spi_sdi_in(1'b0), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
        .upper_pos_in(1'b0), .upper_neg_in(1'b0), .upper_pos_out(up_p),
        .upper_neg_out(up_n), .upper_pos_oe_out(up_oe), .upper_neg_oe_out(up_noe),
        .core_standby_in(standby), .core_read_in(rd), .core_own_in(own),
        .core_bit_in(obit), .core_csb_out(csb), .core_sck_out(sck),
        .core_sdi_out(sdi), .iface_ready_out(ready));
    slw_host_end #(.WAKE_GAP(40), .WAKE_CYCLES(20), .READY_CYCLES(5))
    u_slw_host_end (.clock_in(clk), .rstn_in(rstn), .link(lnk),
        .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
        .cmd_ready_out(cmd_ready), .rx_valid_out(rx_valid),
        .rx_bit_out(rx_bit), .wake_start_in(wake_start),
        .wake_method_in(wake_method), .wake_count_in(wcnt),
        .wake_busy_out(wake_busy));
    slw_link_asserts u_slw_link_asserts (.clock_in(clk), .rstn_in(rstn),
        .host_pos(lnk.host_pos), .host_neg(lnk.host_neg),
        .host_pos_oe(lnk.host_pos_oe), .host_neg_oe(lnk.host_neg_oe),
        .dev_pos(lnk.dev_pos), .dev_neg(lnk.dev_neg),
        .dev_pos_oe(lnk.dev_pos_oe), .dev_neg_oe(lnk.dev_neg_oe),
        .lower_pos_line(lnk.lower_pos_line),
        .lower_neg_line(lnk.lower_neg_line));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: got %0h want %0h", $time, got, exp);
        end
    endtask
    // One host event; bounded wait so a lost answer cannot hang the run
    task automatic send(input logic [1:0] c, output logic b);
        b = 1'bx;
        cmd_code = c;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            if (rx_valid === 1'b1) b = rx_bit;
            if (cmd_ready === 1'b1) break;
        end
        repeat (8) @(negedge clk);
    endtask
    task automatic wake(input logic m, input logic s);
        wake_method = m;
        standby = s;
        wake_start = 1'b1;
        @(negedge clk);
        wake_start = 1'b0;
        for (int n = 0; n < 400 && wake_busy === 1'b1; n++) @(negedge clk);
        repeat (10) @(negedge clk);
    endtask
    // Pair wake from idle; device wakes the one above exactly once
    task automatic t_pair_wake();
        logic [7:0] u0;
        u0 = ups;
        wake(1'b1, 1'b0);
        chk({7'h0, ready}, 8'h1);
        chk(ups - u0, 8'h4);
    endtask
    // Select framing around every bit kind, with and without a read
    task automatic t_read();
        logic b;
        logic [7:0] u0;
        u0 = ups;
        send(2'h1, b);
        chk({7'h0, csb}, 8'h0);
        for (int i = 0; i < 6; i++) begin
            rd = (i < 4);
            obit = i[1];
            send({1'b1, i[0]}, b);
            chk({7'h0, b}, {7'h0, ~(rd & ~obit)});
            chk({7'h0, sdi}, {7'h0, i[0]});
            chk({2'h0, up_p, up_n, sdo, sdo_oe, sck, up_noe}, 8'h0);
        end
        send(2'h0, b);
        chk({7'h0, csb}, 8'h1);
        chk(ups - u0, 8'h14);
    endtask
    // Silence past the idle span, then one pair plus a dummy byte
    task automatic t_idle_wake();
        logic [7:0] u0;
        repeat (210) @(negedge clk);
        chk({7'h0, ready}, 8'h0);
        u0 = ups;
        wake(1'b0, 1'b1);
        chk({7'h0, ready}, 8'h1);
        chk({7'h0, ups - u0 >= 8'h14}, 8'h1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_pair_wake();
        t_read();
        t_idle_wake();
        report_and_stop();
    end
    // Watchdog at more than twice the expected run
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule // spi_pulse_link_wake_tb
`default_nettype wire
